//--- logic/anr_consts.svh
`ifndef ANR_CONSTS_SVH
`define ANR_CONSTS_SVH
// Device register indices on the device interface (3-bit address)
`define ANR_IDX_BAUD_CONTROL 3'h0
`define ANR_IDX_RECEIVE_DATA 3'h1
`define ANR_IDX_RECEIVE_CONTROL_STATUS 3'h2
`define ANR_IDX_BAUD_DIVISOR_LOW 3'h3
`define ANR_IDX_BAUD_DIVISOR_HIGH 3'h4
`define ANR_IDX_TRANSMIT_CONTROL_STATUS 3'h5
`define ANR_IDX_INTERRUPT_CONTROL 3'h6
// Receive control/status bit positions
`define ANR_RCS_SERIAL_PORT_EN 7
`define ANR_RCS_NINE_BIT_EN 6
`define ANR_RCS_CONT_RX_EN 4
`define ANR_RCS_ADDR_DET_EN 3
`define ANR_RCS_FRAMING_ERR 2
`define ANR_RCS_OVERRUN_ERR 1
`define ANR_RCS_NINTH_BIT 0
// Baud control and transmit control bit positions
`define ANR_BC_RX_IDLE 6
`define ANR_BC_WIDE_DIV 3
`define ANR_TCS_CLOCKED_MODE 4
`define ANR_TCS_HIGH_SPEED 2
`define ANR_TCS_TX_EMPTY 1
// Interrupt control bits: global, peripheral, receive enable, pending
`define ANR_IC_GLOBAL_EN 7
`define ANR_IC_PERIPH_EN 6
`define ANR_IC_RX_EN 5
`define ANR_IC_RX_PENDING 0
// Reset values
`define ANR_RST_BYTE 8'h00
`define ANR_RST_TCS 8'h02
// Oversampling
`define ANR_OVERSAMPLE 5'h10
`define ANR_HALF_BIT 4'h7
`define ANR_LAST_TICK 4'hF
// Controller APB register offsets (byte addresses)
`define ANR_APB_CMD 12'h000
`define ANR_APB_WDATA 12'h004
`define ANR_APB_STATUS 12'h008
`define ANR_APB_RDATA 12'h00C
`define ANR_CMD_GO 8
`define ANR_CMD_WRITE 9
`define ANR_CMD_ADDR_LSB 0
`endif

//--- logic/anr_pkg.sv
package anr_pkg;
    typedef logic [2:0] anr_addr_t;
    typedef logic [7:0] anr_byte_t;
    typedef enum logic [3:0] {
        RX_IDLE = 4'h1,
        RX_START = 4'h2,
        RX_DATA = 4'h4,
        RX_STOP = 4'h8
    } anr_rx_state_e;
    typedef enum logic [2:0] {
        CT_IDLE = 3'h1,
        CT_REQ = 3'h2,
        CT_DONE = 3'h4
    } anr_ct_state_e;
endpackage : anr_pkg

//--- logic/anr_if.sv
interface anr_if (
    input wire logic clk,
    input wire logic sys_rst
);
    // Register access from the controller
    logic regSel;
    logic regWrite;
    anr_pkg::anr_addr_t regAddr;
    anr_pkg::anr_byte_t regWdata;
    anr_pkg::anr_byte_t regRdata;
    logic regAck;
    // Interrupt request back to the controller
    logic rxIrq;

    modport device (
        input regSel, regWrite, regAddr, regWdata,
        output regRdata, regAck, rxIrq
    );
    modport host (
        output regSel, regWrite, regAddr, regWdata,
        input regRdata, regAck, rxIrq
    );
endinterface : anr_if

//--- logic/anr_receiver.sv
`include "anr_consts.svh"
module anr_receiver (
    // Clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // Register side
    anr_if.device bus,
    // Serial line
    input wire logic rxLine
);
    logic [7:0] rcs_q;
    logic [7:0] baudCtl_q;
    logic [7:0] tcs_q;
    logic [7:0] divLo_q;
    logic [7:0] divHi_q;
    logic [7:0] intCtl_q;
    logic [15:0] baudCnt_q;
    logic tick;
    anr_pkg::anr_rx_state_e state_q;
    logic [3:0] subCnt_q;
    logic [3:0] bitCnt_q;
    logic [8:0] shift_q;
    logic [2:0] votes_q;
    logic [9:0] fifoData_q [2];
    logic fifoHead_q;
    logic [1:0] fifoCount_q;
    logic overrun_q;
    logic lineLast_q;
    logic [7:0] rdata_q;
    logic portOn;
    logic rxOn;
    logic charDone;
    logic stopBit;
    logic accept;
    logic keep;
    logic readData;
    logic [15:0] divisor;
    logic [9:0] head;

    function automatic logic majority(input logic [2:0] v);
        majority = (v[0] & v[1]) | (v[0] & v[2]) | (v[1] & v[2]);
    endfunction : majority

    assign portOn = rcs_q[`ANR_RCS_SERIAL_PORT_EN] & ~tcs_q[`ANR_TCS_CLOCKED_MODE];
    assign rxOn = portOn & rcs_q[`ANR_RCS_CONT_RX_EN];
    assign divisor = baudCtl_q[`ANR_BC_WIDE_DIV] ? {divHi_q, divLo_q} : {8'h00, divLo_q};
    assign head = fifoData_q[fifoHead_q];
    assign readData = bus.regSel & ~bus.regWrite & (bus.regAddr == `ANR_IDX_RECEIVE_DATA);
    assign bus.regAck = bus.regSel;

    // Oversample tick: sixteen per bit
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            baudCnt_q <= 16'h0000;
        end else if (!portOn || baudCnt_q >= divisor) begin
            baudCnt_q <= 16'h0000;
        end else begin
            baudCnt_q <= baudCnt_q + 16'h0001;
        end
    end
    assign tick = portOn & (baudCnt_q >= divisor);

    // Receive bit engine
    assign stopBit = majority(votes_q);
    assign charDone = tick && state_q == anr_pkg::RX_STOP && subCnt_q == `ANR_LAST_TICK;
    // Filter decision: dropped characters neither fill nor overrun the FIFO
    assign keep = !(rcs_q[`ANR_RCS_ADDR_DET_EN] && rcs_q[`ANR_RCS_NINE_BIT_EN]) || shift_q[8];
    // A read in the same cycle frees a slot for the incoming character
    assign accept = charDone && keep && !overrun_q && (fifoCount_q != 2'h2 || readData);

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            state_q <= anr_pkg::RX_IDLE;
            subCnt_q <= 4'h0;
            bitCnt_q <= 4'h0;
            shift_q <= 9'h000;
            votes_q <= 3'h0;
            lineLast_q <= 1'b1;
        end else if (!rxOn || overrun_q) begin
            state_q <= anr_pkg::RX_IDLE;
            lineLast_q <= 1'b1;
        end else begin
            lineLast_q <= rxLine;
            if (tick) begin
                subCnt_q <= subCnt_q + 4'h1;
                if (subCnt_q >= 4'h6 && subCnt_q <= 4'h8) begin
                    votes_q <= {votes_q[1:0], rxLine};
                end
            end
            case (state_q)
                anr_pkg::RX_IDLE: begin
                    if (lineLast_q && !rxLine) begin
                        state_q <= anr_pkg::RX_START;
                        subCnt_q <= 4'h0;
                    end
                end
                anr_pkg::RX_START: begin
                    if (tick && subCnt_q == `ANR_HALF_BIT) begin
                        if (rxLine) begin
                            state_q <= anr_pkg::RX_IDLE;
                        end
                    end else if (tick && subCnt_q == `ANR_LAST_TICK) begin
                        state_q <= anr_pkg::RX_DATA;
                        bitCnt_q <= 4'h0;
                    end
                end
                anr_pkg::RX_DATA: begin
                    if (tick && subCnt_q == `ANR_LAST_TICK) begin
                        if (rcs_q[`ANR_RCS_NINE_BIT_EN]) begin
                            shift_q <= {majority(votes_q), shift_q[8:1]};
                        end else begin
                            shift_q <= {1'b0, majority(votes_q), shift_q[7:1]};
                        end
                        bitCnt_q <= bitCnt_q + 4'h1;
                        if (bitCnt_q == (rcs_q[`ANR_RCS_NINE_BIT_EN] ? 4'h8 : 4'h7)) begin
                            state_q <= anr_pkg::RX_STOP;
                        end
                    end
                end
                anr_pkg::RX_STOP: begin
                    if (charDone) begin
                        state_q <= anr_pkg::RX_IDLE;
                    end
                end
                default: begin
                    state_q <= anr_pkg::RX_IDLE;
                end
            endcase
        end
    end

    // Two-entry FIFO with ninth bit and framing error per entry
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            fifoData_q[0] <= 10'h000;
            fifoData_q[1] <= 10'h000;
            fifoHead_q <= 1'b0;
            fifoCount_q <= 2'h0;
        end else if (!portOn) begin
            fifoHead_q <= 1'b0;
            fifoCount_q <= 2'h0;
            fifoData_q[0] <= 10'h000;
            fifoData_q[1] <= 10'h000;
        end else begin
            if (accept) begin
                fifoData_q[fifoHead_q ^ fifoCount_q[0]] <= {~stopBit, shift_q};
            end
            if (readData && fifoCount_q != 2'h0) begin
                fifoHead_q <= ~fifoHead_q;
            end
            fifoCount_q <= fifoCount_q + {1'b0, accept} - {1'b0, readData && fifoCount_q != 2'h0};
        end
    end

    // Overrun: third complete character with FIFO full
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            overrun_q <= 1'b0;
        end else if (!rxOn) begin
            overrun_q <= 1'b0;
        end else if (charDone && keep && fifoCount_q == 2'h2 && !readData) begin
            overrun_q <= 1'b1;
        end
    end

    // Register writes
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            rcs_q <= `ANR_RST_BYTE;
            baudCtl_q <= `ANR_RST_BYTE;
            tcs_q <= `ANR_RST_TCS;
            divLo_q <= `ANR_RST_BYTE;
            divHi_q <= `ANR_RST_BYTE;
            intCtl_q <= `ANR_RST_BYTE;
        end else if (bus.regSel && bus.regWrite) begin
            case (bus.regAddr)
                `ANR_IDX_RECEIVE_CONTROL_STATUS: rcs_q <= bus.regWdata & 8'hF8;
                `ANR_IDX_BAUD_CONTROL: baudCtl_q <= bus.regWdata & 8'h08;
                `ANR_IDX_TRANSMIT_CONTROL_STATUS: tcs_q <= (bus.regWdata & 8'h14) | `ANR_RST_TCS;
                `ANR_IDX_BAUD_DIVISOR_LOW: divLo_q <= bus.regWdata;
                `ANR_IDX_BAUD_DIVISOR_HIGH: divHi_q <= bus.regWdata;
                `ANR_IDX_INTERRUPT_CONTROL: intCtl_q <= bus.regWdata & 8'hE0;
                default: begin
                end
            endcase
        end
    end

    // Register reads, registered data
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            rdata_q <= `ANR_RST_BYTE;
        end else if (bus.regSel && !bus.regWrite) begin
            case (bus.regAddr)
                `ANR_IDX_RECEIVE_CONTROL_STATUS: rdata_q <= {rcs_q[7:3], head[9] & (fifoCount_q != 2'h0),
                    overrun_q, head[8]};
                `ANR_IDX_RECEIVE_DATA: rdata_q <= head[7:0];
                `ANR_IDX_BAUD_CONTROL: rdata_q <= baudCtl_q | {1'b0, state_q == anr_pkg::RX_IDLE, 6'h00};
                `ANR_IDX_TRANSMIT_CONTROL_STATUS: rdata_q <= tcs_q;
                `ANR_IDX_BAUD_DIVISOR_LOW: rdata_q <= divLo_q;
                `ANR_IDX_BAUD_DIVISOR_HIGH: rdata_q <= divHi_q;
                `ANR_IDX_INTERRUPT_CONTROL: rdata_q <= intCtl_q | {7'h00, fifoCount_q != 2'h0};
                default: rdata_q <= `ANR_RST_BYTE;
            endcase
        end
    end
    assign bus.regRdata = rdata_q;

    // Pending flag gated by three enables
    assign bus.rxIrq = (fifoCount_q != 2'h0) & intCtl_q[`ANR_IC_RX_EN] &
        intCtl_q[`ANR_IC_PERIPH_EN] & intCtl_q[`ANR_IC_GLOBAL_EN];
endmodule : anr_receiver

//--- logic/anr_controller.sv
`include "anr_consts.svh"
module anr_controller (
    // Clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Device side
    anr_if.host dev
);
    logic [9:0] cmd_q;
    logic [7:0] wdata_q;
    logic [7:0] rdata_q;
    anr_pkg::anr_ct_state_e state_q;
    logic [31:0] prdata_q;
    logic apbWr;
    logic apbRd;

    assign apbWr = psel & penable & pwrite;
    assign apbRd = psel & ~penable & ~pwrite;
    assign pready = 1'b1;
    assign pslverr = 1'b0;
    assign prdata = prdata_q;

    // Command sequencer: software orders set-up steps
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            state_q <= anr_pkg::CT_IDLE;
            cmd_q <= 10'h000;
            wdata_q <= 8'h00;
            rdata_q <= 8'h00;
        end else begin
            case (state_q)
                anr_pkg::CT_IDLE: begin
                    if (apbWr && paddr == `ANR_APB_WDATA) begin
                        wdata_q <= pwdata[7:0];
                    end
                    if (apbWr && paddr == `ANR_APB_CMD && pwdata[`ANR_CMD_GO]) begin
                        cmd_q <= pwdata[9:0];
                        state_q <= anr_pkg::CT_REQ;
                    end
                end
                anr_pkg::CT_REQ: begin
                    if (dev.regAck) begin
                        state_q <= anr_pkg::CT_DONE;
                    end
                end
                anr_pkg::CT_DONE: begin
                    rdata_q <= dev.regRdata;
                    state_q <= anr_pkg::CT_IDLE;
                end
                default: begin
                    state_q <= anr_pkg::CT_IDLE;
                end
            endcase
        end
    end

    assign dev.regSel = (state_q == anr_pkg::CT_REQ);
    assign dev.regWrite = cmd_q[`ANR_CMD_WRITE];
    assign dev.regAddr = cmd_q[2:0];
    assign dev.regWdata = wdata_q;

    // APB read data
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            prdata_q <= 32'h00000000;
        end else if (apbRd) begin
            case (paddr)
                `ANR_APB_CMD: prdata_q <= {22'h000000, cmd_q};
                `ANR_APB_WDATA: prdata_q <= {24'h000000, wdata_q};
                `ANR_APB_STATUS: prdata_q <= {30'h00000000, dev.rxIrq, state_q != anr_pkg::CT_IDLE};
                `ANR_APB_RDATA: prdata_q <= {24'h000000, rdata_q};
                default: prdata_q <= 32'h00000000;
            endcase
        end
    end
endmodule : anr_controller

//--- tb/anr_checker.sv
module anr_checker (
    // Clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // Interface signals
    input wire logic regSel,
    input wire logic regWrite,
    input wire anr_pkg::anr_addr_t regAddr,
    input wire anr_pkg::anr_byte_t regWdata,
    input wire anr_pkg::anr_byte_t regRdata,
    input wire logic regAck,
    input wire logic rxIrq
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [7:0] rcsQ;
    logic [2:0] icQ;
    wire logic wrEv = regSel && regWrite;
    wire logic rdEv = regSel && !regWrite;
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (sys_rst);
    // Shadow of receive control writes
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) rcsQ <= 8'h00;
        else if (wrEv && regAddr == 3'h2) rcsQ <= regWdata;
    end
    // Shadow of interrupt enable writes
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) icQ <= 3'h0;
        else if (wrEv && regAddr == 3'h6) icQ <= regWdata[7:5];
    end
    chk_ack_same: assert property (regAck == regSel)
        else $error("ack differs from select");
    chk_sel_single: assert property (regSel |=> !regSel)
        else $error("select held two cycles");
    chk_irq_gated: assert property (rxIrq |-> icQ == 3'h7)
        else $error("interrupt without all enables");
    chk_port_flush: assert property (wrEv && regAddr == 3'h2 && !regWdata[7] |=> ##1 !rxIrq)
        else $error("interrupt after port disable");
    chk_filter_ninth: assert property (rdEv && regAddr == 3'h2 && rcsQ[6] && rcsQ[3] && rxIrq
        |=> regRdata[0])
        else $error("filtered character with ninth bit zero");
    chk_ctrl_readback: assert property (rdEv && regAddr == 3'h2
        |=> {regRdata[7:6], regRdata[4:3]} == {rcsQ[7:6], rcsQ[4:3]})
        else $error("receive control readback wrong");
    chk_pending_irq: assert property (rdEv && regAddr == 3'h6 && icQ == 3'h7
        |=> regRdata[0] == $past(rxIrq))
        else $error("pending flag differs from interrupt");
    chk_enable_readback: assert property (rdEv && regAddr == 3'h6 |=> regRdata[7:5] == icQ)
        else $error("interrupt enable readback wrong");
    cover property (rxIrq);
    cover property (rdEv && regAddr == 3'h1);
    cover property (wrEv && regAddr == 3'h2 && regWdata[3]);
endmodule : anr_checker

//--- tb/async_rx_nine_bit_address_detect_test.sv
`include "anr_consts.svh"
module async_rx_nine_bit_address_detect_test;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int BitClk = 32;
    logic clk, sys_rst, psel, penable, pwrite, rxLine, pready, pslverr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, expV, mskV, r;
    logic [31:0] noteQ[$];
    logic [31:0] maskQ[$];
    logic [8:0] a, b, c0, c1, c2;
    int errorCnt = 0;
    int comparisons = 0;
    anr_if bus (.clk(clk), .sys_rst(sys_rst));
    anr_receiver i_anr_receiver (.clk(clk), .sys_rst(sys_rst), .bus(bus), .rxLine(rxLine));
    anr_controller i_anr_controller (.clk(clk), .sys_rst(sys_rst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .dev(bus));
    anr_checker i_anr_checker (.clk(clk), .sys_rst(sys_rst), .regSel(bus.regSel),
        .regWrite(bus.regWrite), .regAddr(bus.regAddr), .regWdata(bus.regWdata),
        .regRdata(bus.regRdata), .regAck(bus.regAck), .rxIrq(bus.rxIrq));
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    task automatic printVerdict;
        $display("comparisons %0d errors %0d", comparisons, errorCnt);
        if (errorCnt == 0 && comparisons > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : printVerdict
    task automatic apb(input logic wr, input logic [11:0] ad, input logic [31:0] d,
        input logic [31:0] e, input logic [31:0] m, output logic [31:0] rv);
        if (!wr) begin
            noteQ.push_back(e);
            maskQ.push_back(m);
        end
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= ad;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1) @(posedge clk);
        rv = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask : apb
    task automatic waitIdle;
        logic [31:0] s;
        int n;
        n = 0;
        do begin
            apb(1'b0, `ANR_APB_STATUS, 32'h0, 32'h0, 32'h0, s);
            n++;
        end while (s[0] !== 1'b0 && n < 20);
        if (n >= 20) begin
            errorCnt++;
            $display("unexpected busy exp 0 seen 1");
        end
    endtask : waitIdle
    task automatic devWr(input logic [2:0] i, input logic [7:0] v);
        logic [31:0] d;
        apb(1'b1, `ANR_APB_WDATA, {24'h0, v}, 32'h0, 32'h0, d);
        apb(1'b1, `ANR_APB_CMD, {20'h0, 12'h300} | {29'h0, i}, 32'h0, 32'h0, d);
        waitIdle();
    endtask : devWr
    task automatic devRd(input logic [2:0] i, input logic [7:0] e, input logic [7:0] m);
        logic [31:0] d;
        apb(1'b1, `ANR_APB_CMD, {20'h0, 12'h100} | {29'h0, i}, 32'h0, 32'h0, d);
        waitIdle();
        apb(1'b0, `ANR_APB_RDATA, 32'h0, {24'h0, e}, {24'h0, m}, d);
    endtask : devRd
    task automatic rdChar(input logic [8:0] v, input logic [7:0] st);
        devRd(3'h2, st | {7'h0, v[8]}, 8'hDF);
        devRd(3'h1, v[7:0], 8'hFF);
    endtask : rdChar
    task automatic send(input logic [8:0] v, input logic nine, input logic stopV);
        rxLine <= 1'b0;
        repeat (BitClk) @(posedge clk);
        for (int i = 0; i < 9; i++) if (i < 8 || nine) begin
            rxLine <= v[i];
            repeat (BitClk) @(posedge clk);
        end
        rxLine <= stopV;
        repeat (BitClk) @(posedge clk);
        rxLine <= 1'b1;
        repeat (BitClk) @(posedge clk);
    endtask : send
    // Results are compared in order of the notes
    always @(posedge clk) begin
        if (psel && penable && pready && !pwrite && noteQ.size() > 0) begin
            expV = noteQ.pop_front();
            mskV = maskQ.pop_front();
            if (mskV != 32'h0) begin
                comparisons++;
                if ((prdata & mskV) !== (expV & mskV)) begin
                    errorCnt++;
                    $display("unexpected prdata exp %h seen %h", expV & mskV, prdata & mskV);
                end
            end
        end
    end
    initial begin
        repeat (60000) @(posedge clk);
        errorCnt++;
        $display("unexpected timeout exp done seen hang");
        printVerdict();
    end
    initial begin
        sys_rst = 1'b1;
        {psel, penable, pwrite, rxLine} = 4'h1;
        paddr = 12'h000;
        pwdata = 32'h0;
        void'($urandom(45913));
        repeat (2) @(posedge clk);
        sys_rst <= 1'b0;
        devRd(3'h5, 8'h02, 8'hFF);
        devRd(3'h2, 8'h00, 8'hFF);
        apb(1'b0, 12'h010, 32'h0, 32'h0, 32'hFFFFFFFF, r);
        devWr(3'h3, 8'h01);
        devWr(3'h4, 8'h00);
        devWr(3'h0, 8'h00);
        devWr(3'h6, 8'hE0);
        devWr(3'h2, 8'hC0);
        devWr(3'h2, 8'hD0);
        a = 9'($urandom) | 9'h100;
        b = 9'($urandom) & 9'h0FF;
        send(a, 1'b1, 1'b1);
        send(b, 1'b1, 1'b1);
        rdChar(a, 8'hD0);
        rdChar(b, 8'hD0);
        devRd(3'h6, 8'hE0, 8'hE1);
        c0 = 9'($urandom);
        c1 = 9'($urandom);
        c2 = 9'($urandom);
        send(c0, 1'b1, 1'b1);
        send(c1, 1'b1, 1'b1);
        send(c2, 1'b1, 1'b1);
        rdChar(c0, 8'hD2);
        devWr(3'h2, 8'hC0);
        devRd(3'h2, 8'hC0 | {7'h0, c1[8]}, 8'hDF);
        devWr(3'h2, 8'hD0);
        devRd(3'h1, c1[7:0], 8'hFF);
        devRd(3'h6, 8'hE0, 8'hE1);
        devWr(3'h2, 8'hD8);
        send(b, 1'b1, 1'b1);
        devRd(3'h6, 8'hE0, 8'hE1);
        send(a, 1'b1, 1'b1);
        rdChar(a, 8'hD8);
        devWr(3'h2, 8'hD0);
        send(b, 1'b1, 1'b1);
        rdChar(b, 8'hD0);
        devWr(3'h2, 8'hD8);
        send(b, 1'b1, 1'b1);
        devRd(3'h6, 8'hE0, 8'hE1);
        devWr(3'h2, 8'hD0);
        send(a, 1'b1, 1'b0);
        rdChar(a, 8'hD4);
        send(b, 1'b1, 1'b1);
        rdChar(b, 8'hD0);
        rxLine <= 1'b0;
        repeat (4) @(posedge clk);
        rxLine <= 1'b1;
        // Long enough for a falsely started character to complete
        repeat (12 * BitClk) @(posedge clk);
        devRd(3'h6, 8'hE0, 8'hE1);
        devWr(3'h2, 8'h90);
        send(a, 1'b0, 1'b1);
        devRd(3'h1, a[7:0], 8'hFF);
        devWr(3'h6, 8'h60);
        send(b, 1'b0, 1'b1);
        devRd(3'h6, 8'h61, 8'hE1);
        devWr(3'h6, 8'hE0);
        devWr(3'h2, 8'h10);
        devRd(3'h6, 8'hE0, 8'hE1);
        printVerdict();
    end
endmodule : async_rx_nine_bit_address_detect_test
